/* File: verilog/rwt_consts.svh */
// Register offsets, fields, reset values and timing counts of the wake-up criteria block
// What this block does
// - Hold a 7-bit wake count, 0 to 127, bounding data-criterion examination after sync.
// - Wake count counts bits, or chips when pattern matching runs in chip units.
// - Count zero in random or equal bits wakes immediately at symbol sync.
// - Count zero in pattern detection never gives a data wake-up.
// - Pattern compare starts only once its register is full after 17 units; needs count of at least 18.
// - RSSI criterion requests wake-up while channel 1 RSSI exceeds the 8-bit threshold.
// - Provide an 8-bit lower RSSI blocking level, reset all ones.
// - Use an 8-bit upper RSSI blocking level for RSSI wake or fall back, reset zero.
// - Signal recognition wakes after staying high the programmed consecutive T/16 samples.
// - Hold an 8-bit peak detector saturation threshold, reset 0x10.
// - Prescaler code 0 to 7 selects factor 4, 8, 16 up to 512.
// - Observation time is count times factor times 64 clocks, count 1 to 31.
// - Observation count zero counts as 32.
// - Sync search timeout is 8 bits in sixteenth bits, reset 0x87.
// - Sync timer forces run-mode self polling back to self polling without sync.
// - Sync timeout is setting times 64 times 512 clocks; zero disables; reset 0xFF.
// - Sync timer restarts at every new run-mode self polling cycle.
// - Pattern unit select clear picks chips, set picks bits.
// - Wake on symbol sync with valid data rate ignores the wake count.
`ifndef RWT_CONSTS_SVH
`define RWT_CONSTS_SVH

`define RWT_ADDR_W 8
`define RWT_DATA_W 8

`define RWT_OFS_WAKE_CTRL 8'h17
`define RWT_OFS_WAKE_COUNT 8'h1A
`define RWT_OFS_RSSI_THR 8'h1B
`define RWT_OFS_RSSI_BLK_LO 8'h1C
`define RWT_OFS_RSSI_BLK_HI 8'h1D
`define RWT_OFS_PEAK_SAT 8'h24
`define RWT_OFS_LEVEL_OBS 8'h25
`define RWT_OFS_SYNC_SEARCH 8'h26
`define RWT_OFS_SYNC_LOSS 8'h27
`define RWT_OFS_STATUS 8'h30

`define RWT_RST_WAKE_CTRL 8'h04
`define RWT_RST_WAKE_COUNT 7'h00
`define RWT_RST_RSSI_THR 8'h00
`define RWT_RST_RSSI_BLK_LO 8'hFF
`define RWT_RST_RSSI_BLK_HI 8'h00
`define RWT_RST_PEAK_SAT 8'h10
`define RWT_RST_LEVEL_OBS 8'h00
`define RWT_RST_SYNC_SEARCH 8'h87
`define RWT_RST_SYNC_LOSS 8'hFF

`define RWT_CTRL_UNIT_BIT 5
`define RWT_CTRL_LVL_SEL_BIT 4
`define RWT_CTRL_FFB_BIT 3
`define RWT_CTRL_MASK 8'h3F

`define RWT_CRIT_PATTERN 3'h0
`define RWT_CRIT_RANDOM 3'h1
`define RWT_CRIT_EQUAL 3'h2
`define RWT_CRIT_SYNC_RATE 3'h3
`define RWT_CRIT_RSSI 3'h4
`define RWT_CRIT_SIGREC 3'h5

`define RWT_PATTERN_FILL 7'h11
`define RWT_OBS_BASE_CYC 64
`define RWT_SYNC_UNIT_CYC 32768

`endif

/* File: verilog/rwt_pkg.sv */
// Types shared by the wake-up criteria block
package rwt_pkg;

  typedef struct packed {
    logic       sym_sync;
    logic       rate_valid;
    logic       bit_tick;
    logic       chip_tick;
    logic       data_ok;
    logic       pattern_match;
    logic [7:0] rssi;
    logic       sig_rec;
    logic       t16_tick;
  } rwt_demod_t;

  typedef struct packed {
    logic data_wake;
    logic level_wake;
    logic sync_timeout;
    logic observe_done;
  } rwt_event_t;

  typedef enum logic [1:0] {
    DW_IDLE,
    DW_COUNT,
    DW_DONE
  } rwt_dwin_t;

endpackage

/* File: verilog/rwt_core.sv */
// Wake-up criteria decision logic, observation and sync timeout timers, registers
`timescale 1ns/1ns
`include "rwt_consts.svh"

module rwt_core import rwt_pkg::*; #(
  parameter int SYNC_UNIT_CYC = `RWT_SYNC_UNIT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_cycle_start,
  input  wire rwt_demod_t i_demod,
  output logic [7:0]      o_rdata,
  output rwt_event_t      o_event,
  output logic            o_pattern_armed,
  output logic [7:0]      o_peak_sat,
  output logic [7:0]      o_search_timeout
);

  // Observation unit base in clocks
  localparam logic [6:0] OBS_BASE = 7'(`RWT_OBS_BASE_CYC);
  localparam logic [15:0] SYNC_UNIT = 16'(SYNC_UNIT_CYC - 1);

  function automatic logic [9:0] prescale_factor(input logic [2:0] code);
    prescale_factor = 10'h004 << code;
  endfunction

  function automatic logic is_data_crit(input logic [2:0] crit);
    is_data_crit = (crit <= `RWT_CRIT_SYNC_RATE);
  endfunction

  // Registers
  logic [7:0] ctrl_reg;
  logic [6:0] wake_count_reg;
  logic [7:0] rssi_thr_reg;
  logic [7:0] rssi_lo_reg;
  logic [7:0] rssi_hi_reg;
  logic [7:0] peak_sat_reg;
  logic [7:0] obs_reg;
  logic [7:0] search_reg;
  logic [7:0] sync_loss_reg;
  logic [7:0] rdata_reg;

  // Register write decode
  wire wr_ctrl = i_wr && (i_addr == `RWT_OFS_WAKE_CTRL);
  wire wr_cnt = i_wr && (i_addr == `RWT_OFS_WAKE_COUNT);
  wire wr_thr = i_wr && (i_addr == `RWT_OFS_RSSI_THR);
  wire wr_lo = i_wr && (i_addr == `RWT_OFS_RSSI_BLK_LO);
  wire wr_hi = i_wr && (i_addr == `RWT_OFS_RSSI_BLK_HI);
  wire wr_sat = i_wr && (i_addr == `RWT_OFS_PEAK_SAT);
  wire wr_obs = i_wr && (i_addr == `RWT_OFS_LEVEL_OBS);
  wire wr_srch = i_wr && (i_addr == `RWT_OFS_SYNC_SEARCH);
  wire wr_loss = i_wr && (i_addr == `RWT_OFS_SYNC_LOSS);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= `RWT_RST_WAKE_CTRL;
      wake_count_reg <= `RWT_RST_WAKE_COUNT;
      rssi_thr_reg <= `RWT_RST_RSSI_THR;
      rssi_lo_reg <= `RWT_RST_RSSI_BLK_LO;
      rssi_hi_reg <= `RWT_RST_RSSI_BLK_HI;
      peak_sat_reg <= `RWT_RST_PEAK_SAT;
      obs_reg <= `RWT_RST_LEVEL_OBS;
      search_reg <= `RWT_RST_SYNC_SEARCH;
      sync_loss_reg <= `RWT_RST_SYNC_LOSS;
    end else begin
      if (wr_ctrl) ctrl_reg <= i_wdata & `RWT_CTRL_MASK;
      if (wr_cnt) wake_count_reg <= i_wdata[6:0];
      if (wr_thr) rssi_thr_reg <= i_wdata;
      if (wr_lo) rssi_lo_reg <= i_wdata;
      if (wr_hi) rssi_hi_reg <= i_wdata;
      if (wr_sat) peak_sat_reg <= i_wdata;
      if (wr_obs) obs_reg <= i_wdata;
      if (wr_srch) search_reg <= i_wdata;
      if (wr_loss) sync_loss_reg <= i_wdata;
    end
  end

  // Control fields
  wire [2:0] crit = ctrl_reg[2:0];
  wire unit_bits = ctrl_reg[`RWT_CTRL_UNIT_BIT];
  wire ffb_en = ctrl_reg[`RWT_CTRL_FFB_BIT];
  wire lvl_sigrec = ctrl_reg[`RWT_CTRL_LVL_SEL_BIT];

  // Level criterion: selected directly, or in parallel with a data criterion
  wire use_rssi = (crit == `RWT_CRIT_RSSI) ||
    (ffb_en && is_data_crit(crit) && !lvl_sigrec);
  wire use_sigrec = (crit == `RWT_CRIT_SIGREC) ||
    (ffb_en && is_data_crit(crit) && lvl_sigrec);

  // Data criterion window after symbol sync
  rwt_dwin_t dwin_reg;
  rwt_dwin_t dwin_next;
  logic [6:0] unit_cnt_reg;
  logic sync_d_reg;
  logic data_wake_reg;

  wire sync_rise = i_demod.sym_sync && !sync_d_reg;
  wire is_pattern = (crit == `RWT_CRIT_PATTERN);
  wire chip_units = is_pattern && !unit_bits;
  wire unit_tick = chip_units ? i_demod.chip_tick : i_demod.bit_tick;
  wire win_end = (unit_cnt_reg >= wake_count_reg);
  wire pat_armed = (unit_cnt_reg >= `RWT_PATTERN_FILL);
  wire rnd_eq = (crit == `RWT_CRIT_RANDOM) || (crit == `RWT_CRIT_EQUAL);

  // Data wake decision per criterion
  wire wake_imm = sync_rise && rnd_eq && (wake_count_reg == 7'h00);
  wire wake_rnd = (dwin_reg == DW_COUNT) && rnd_eq && i_demod.data_ok;
  wire wake_pat = (dwin_reg == DW_COUNT) && is_pattern && pat_armed &&
    i_demod.pattern_match && (wake_count_reg != 7'h00);
  // The count is not consulted at all for the sync and rate criterion
  wire wake_sr = sync_rise && (crit == `RWT_CRIT_SYNC_RATE) &&
    i_demod.rate_valid;
  wire data_wake = wake_imm || wake_rnd || wake_pat || wake_sr;

  always_comb begin
    dwin_next = dwin_reg;
    unique case (dwin_reg)
      DW_IDLE: begin
        if (sync_rise && is_data_crit(crit) && (crit != `RWT_CRIT_SYNC_RATE)) begin
          dwin_next = (wake_count_reg == 7'h00) ? DW_DONE : DW_COUNT;
        end
      end
      DW_COUNT: begin
        if (data_wake || (unit_tick && (unit_cnt_reg + 7'h01 >= wake_count_reg))) begin
          dwin_next = DW_DONE;
        end
      end
      DW_DONE: begin
        dwin_next = DW_DONE;
      end
    endcase
    if (i_cycle_start || !i_demod.sym_sync) begin
      dwin_next = DW_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dwin_reg <= DW_IDLE;
      unit_cnt_reg <= 7'h00;
      sync_d_reg <= 1'b0;
      data_wake_reg <= 1'b0;
    end else begin
      dwin_reg <= dwin_next;
      sync_d_reg <= i_demod.sym_sync;
      data_wake_reg <= data_wake;
      if (dwin_next == DW_IDLE || dwin_reg == DW_IDLE) begin
        unit_cnt_reg <= 7'h00;
      end else if (dwin_reg == DW_COUNT && unit_tick && !win_end) begin
        unit_cnt_reg <= unit_cnt_reg + 7'h01;
      end
    end
  end

  // RSSI criterion: above threshold and outside the blocking band
  wire rssi_above = (i_demod.rssi > rssi_thr_reg);
  // Reset values make the band empty, so nothing is blocked by default
  wire rssi_blocked = (i_demod.rssi >= rssi_lo_reg) &&
    (i_demod.rssi <= rssi_hi_reg);
  wire rssi_ok = use_rssi && rssi_above && !rssi_blocked;

  // Signal recognition persistence over T/16 samples
  logic [7:0] sr_run_reg;
  wire sr_sample = i_demod.t16_tick && i_demod.sig_rec;
  wire [7:0] sr_run_inc = (sr_run_reg == 8'hFF) ? sr_run_reg : sr_run_reg + 8'h01;
  wire sr_ok = use_sigrec && sr_sample &&
    (sr_run_inc >= rssi_hi_reg);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_cycle_start) begin
      sr_run_reg <= 8'h00;
    end else if (i_demod.t16_tick) begin
      sr_run_reg <= i_demod.sig_rec ? sr_run_inc : 8'h00;
    end
  end

  // Level observation window, started at each cycle start while RSSI or signal recognition is in use
  logic obs_run_reg;
  logic [15:0] obs_pre_reg;
  logic [5:0] obs_unit_reg;
  logic level_hit_reg;
  logic level_wake_reg;
  logic obs_done_reg;

  wire [9:0] obs_factor = prescale_factor(obs_reg[7:5]);
  wire [15:0] obs_pre_max = ({6'h00, obs_factor} * {9'h000, OBS_BASE}) - 16'h0001;
  wire [5:0] obs_units = (obs_reg[4:0] == 5'h00) ? 6'h20 : {1'b0, obs_reg[4:0]};
  wire obs_unit_end = obs_run_reg && (obs_pre_reg == obs_pre_max);
  wire obs_end = obs_unit_end && (obs_unit_reg + 6'h01 == obs_units);
  wire level_ok = rssi_ok || sr_ok;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      obs_run_reg <= 1'b0;
      obs_pre_reg <= 16'h0000;
      obs_unit_reg <= 6'h00;
      level_hit_reg <= 1'b0;
      level_wake_reg <= 1'b0;
      obs_done_reg <= 1'b0;
    end else begin
      level_wake_reg <= obs_run_reg && level_ok && !level_hit_reg;
      obs_done_reg <= obs_end;
      if (i_cycle_start) begin
        obs_run_reg <= use_rssi || use_sigrec;
        obs_pre_reg <= 16'h0000;
        obs_unit_reg <= 6'h00;
        level_hit_reg <= 1'b0;
      end else if (obs_run_reg) begin
        if (level_ok) begin
          level_hit_reg <= 1'b1;
        end
        if (obs_end) begin
          obs_run_reg <= 1'b0;
        end
        if (obs_unit_end) begin
          obs_pre_reg <= 16'h0000;
          obs_unit_reg <= obs_unit_reg + 6'h01;
        end else begin
          obs_pre_reg <= obs_pre_reg + 16'h0001;
        end
      end
    end
  end

  // Sync timeout: units of 64*512 clocks, counted down from the setting
  logic sync_run_reg;
  logic [15:0] sync_pre_reg;
  logic [7:0] sync_left_reg;
  logic sync_to_reg;

  wire sync_unit_end = sync_run_reg && (sync_pre_reg == SYNC_UNIT);
  wire sync_expire = sync_unit_end && (sync_left_reg == 8'h01);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_run_reg <= 1'b0;
      sync_pre_reg <= 16'h0000;
      sync_left_reg <= 8'h00;
      sync_to_reg <= 1'b0;
    end else begin
      sync_to_reg <= sync_expire && !i_demod.sym_sync;
      if (i_cycle_start) begin
        sync_run_reg <= (sync_loss_reg != 8'h00);
        sync_pre_reg <= 16'h0000;
        sync_left_reg <= sync_loss_reg;
      end else if (i_demod.sym_sync || sync_expire) begin
        sync_run_reg <= 1'b0;
      end else if (sync_unit_end) begin
        sync_pre_reg <= 16'h0000;
        sync_left_reg <= sync_left_reg - 8'h01;
      end else if (sync_run_reg) begin
        sync_pre_reg <= sync_pre_reg + 16'h0001;
      end
    end
  end

  // Status of the block's own timers and windows
  wire [7:0] status = {3'h0, level_hit_reg, obs_run_reg, pat_armed,
    (dwin_reg == DW_COUNT), sync_run_reg};

  // Read mux, answered one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_addr)
      `RWT_OFS_WAKE_CTRL: rd_mux = ctrl_reg;
      `RWT_OFS_WAKE_COUNT: rd_mux = {1'b0, wake_count_reg};
      `RWT_OFS_RSSI_THR: rd_mux = rssi_thr_reg;
      `RWT_OFS_RSSI_BLK_LO: rd_mux = rssi_lo_reg;
      `RWT_OFS_RSSI_BLK_HI: rd_mux = rssi_hi_reg;
      `RWT_OFS_PEAK_SAT: rd_mux = peak_sat_reg;
      `RWT_OFS_LEVEL_OBS: rd_mux = obs_reg;
      `RWT_OFS_SYNC_SEARCH: rd_mux = search_reg;
      `RWT_OFS_SYNC_LOSS: rd_mux = sync_loss_reg;
      `RWT_OFS_STATUS: rd_mux = status;
      default: rd_mux = 8'h00;
    endcase
  end

  logic armed_reg;
  logic [7:0] sat_out_reg;
  logic [7:0] srch_out_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
      armed_reg <= 1'b0;
      sat_out_reg <= `RWT_RST_PEAK_SAT;
      srch_out_reg <= `RWT_RST_SYNC_SEARCH;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
      armed_reg <= (dwin_reg == DW_COUNT) && is_pattern && pat_armed;
      sat_out_reg <= peak_sat_reg;
      srch_out_reg <= search_reg;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_event = '{data_wake: data_wake_reg, level_wake: level_wake_reg,
    sync_timeout: sync_to_reg, observe_done: obs_done_reg};
  assign o_pattern_armed = armed_reg;
  assign o_peak_sat = sat_out_reg;
  assign o_search_timeout = srch_out_reg;

endmodule // rwt_core

/* File: sim/rwt_core_sva.sv */
// Assertion checker for the wake-up criteria block
`timescale 1ns/1ns
module rwt_core_sva import rwt_pkg::*; #(
  parameter int SYNC_UNIT_CYC = 32768
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cycle_start,
  input wire rwt_demod_t i_demod,
  input wire logic [7:0] o_rdata,
  input wire rwt_event_t o_event,
  input wire logic o_pattern_armed,
  input wire logic [7:0] o_peak_sat,
  input wire logic [7:0] o_search_timeout
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Shadows of bus writes, so no view inside the design is needed
  logic [7:0] ctrl_reg, wcnt_reg, tmo_reg, load_reg;
  logic seen_reg;
  int age_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= 8'h04;
      wcnt_reg <= 8'h00;
      tmo_reg <= 8'hFF;
      load_reg <= 8'h00;
      seen_reg <= 1'b1;
      age_reg <= 0;
    end else begin
      if (i_wr && i_addr == 8'h17) ctrl_reg <= i_wdata;
      if (i_wr && i_addr == 8'h1A) wcnt_reg <= i_wdata;
      if (i_wr && i_addr == 8'h27) tmo_reg <= i_wdata;
      if (i_cycle_start) load_reg <= tmo_reg;
      age_reg <= i_cycle_start ? 1 : age_reg + 1;
      seen_reg <= i_cycle_start ? 1'b0 : seen_reg | i_demod.sym_sync;
    end
  end
  wire [2:0] crit = ctrl_reg[2:0];
  wire zero_cnt = (wcnt_reg[6:0] == 7'h00);
  sequence sync_rise_s;
    $rose(i_demod.sym_sync) && !i_cycle_start;
  endsequence
  property copy_p(a, o);
    logic [7:0] v;
    (i_wr && i_addr == a, v = i_wdata) |-> ##2 o == v;
  endproperty
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  count_top_a: assert property ($past(i_rd) && $past(i_addr) == 8'h1A |-> !o_rdata[7])
    else $error("wake count top bit reads one");
  peak_copy_a: assert property (copy_p(8'h24, o_peak_sat))
    else $error("peak saturation output not updated");
  search_copy_a: assert property (copy_p(8'h26, o_search_timeout))
    else $error("search timeout output not updated");
  reset_out_a: assert property ($fell(i_sys_rst) |-> o_peak_sat == 8'h10 && o_search_timeout == 8'h87)
    else $error("forwarded values wrong after reset");
  tmo_when_a: assert property (o_event.sync_timeout |-> !seen_reg && age_reg == load_reg * SYNC_UNIT_CYC + 1)
    else $error("sync timeout at wrong moment");
  tmo_must_a: assert property (load_reg != 0 && !seen_reg && age_reg == load_reg * SYNC_UNIT_CYC + 1 |-> o_event.sync_timeout)
    else $error("sync timeout missing");
  sync_rate_a: assert property (sync_rise_s ##0 crit == 3'h3 && i_demod.rate_valid |=> o_event.data_wake)
    else $error("no wake on sync with valid rate");
  zero_wake_a: assert property (sync_rise_s ##0 (crit == 3'h1 || crit == 3'h2) && zero_cnt |=> o_event.data_wake)
    else $error("no immediate wake at count zero");
  pattern_zero_a: assert property (crit == 3'h0 && zero_cnt |-> !o_event.data_wake)
    else $error("pattern wake with count zero");
  armed_wake_a: assert property (crit == 3'h0 && o_event.data_wake |-> o_pattern_armed)
    else $error("pattern wake before register full");
endmodule // rwt_core_sva

bind rwt_core rwt_core_sva #(.SYNC_UNIT_CYC(SYNC_UNIT_CYC)) u_sva (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_cycle_start(i_cycle_start), .i_demod(i_demod), .o_rdata(o_rdata), .o_event(o_event),
  .o_pattern_armed(o_pattern_armed), .o_peak_sat(o_peak_sat),
  .o_search_timeout(o_search_timeout));

/* File: sim/tb_rwt_core.sv */
// Self-checking bench for the wake-up criteria block
`timescale 1ns/1ns
module tb_rwt_core;
  import rwt_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_cycle_start = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_peak_sat, o_search_timeout;
  rwt_demod_t i_demod = '0;
  rwt_event_t o_event;
  logic o_pattern_armed;
  int miscompares = 0, total_checks = 0, seed = 32'hf11b89b0, n;
  logic [7:0] mreg [logic [7:0]];
  logic [7:0] ra [9] = '{8'h17, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [7:0] rv [9] = '{8'h04, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h10, 8'h00, 8'h87, 8'hFF};
  always #2 i_clk = ~i_clk;
  rwt_core #(.SYNC_UNIT_CYC(8)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cycle_start(i_cycle_start),
    .i_demod(i_demod), .o_rdata(o_rdata), .o_event(o_event),
    .o_pattern_armed(o_pattern_armed), .o_peak_sat(o_peak_sat),
    .o_search_timeout(o_search_timeout));
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    return a == 8'h17 ? 8'h3F : a == 8'h1A ? 8'h7F : 8'hFF;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    mreg[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1 check(o_rdata, e);
  endtask
  task automatic start;
    i_cycle_start <= 1;
    @(posedge i_clk);
    i_cycle_start <= 0;
  endtask
  // Edges until event bit b pulses, capped at lim
  task automatic count_to(input int b, input int lim, output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      #1 c++;
    end while (!o_event[b] && c < lim);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 0;
    for (int k = 0; k < 9; k++) rd(ra[k], rv[k]);
    check(o_search_timeout, 8'h87);
    $display("reset values done");
    for (int k = 0; k < 9; k++) wr(ra[k], 8'($random(seed)));
    wr(8'h40, 8'hA5);
    rd(8'h40, 8'h00);
    for (int k = 0; k < 9; k++) rd(ra[k], mreg[ra[k]] & msk(ra[k]));
    check(o_peak_sat, mreg[8'h24]);
    check(o_search_timeout, mreg[8'h26]);
    $display("register access done");
    // Pass four is random bits with a nonzero count, woken by the data checker
    for (int cr = 1; cr <= 4; cr++) begin
      wr(8'h17, cr == 4 ? 8'h01 : 8'(cr));
      wr(8'h1A, cr >= 3 ? 8'h05 : 8'h00);
      i_demod.rate_valid <= 1;
      i_demod.data_ok <= 1;
      i_demod.sym_sync <= 1;
      count_to(3, 4, n);
      check(n, cr == 4 ? 2 : 1);
      i_demod <= '0;
      repeat (2) @(posedge i_clk);
    end
    // Chip mode, bit mode, chip mode fed bits only, pattern with count zero
    for (int k = 0; k < 4; k++) begin
      wr(8'h17, k == 1 ? 8'h20 : 8'h00);
      wr(8'h1A, k == 3 ? 8'h00 : 8'h1E);
      i_demod.chip_tick <= (k == 0 || k == 3);
      i_demod.bit_tick <= (k == 1 || k == 2);
      i_demod.pattern_match <= 1;
      i_demod.sym_sync <= 1;
      count_to(3, 18, n);
      check(n, 18);
      count_to(3, 8, n);
      check(n, k < 2 ? 1 : 8);
      check(o_pattern_armed, k < 2);
      i_demod <= '0;
      repeat (2) @(posedge i_clk);
    end
    $display("data criteria done");
    wr(8'h1B, 8'h40);
    wr(8'h25, 8'h01);
    for (int k = 0; k < 4; k++) begin
      // Last pass reaches RSSI as the parallel level criterion beside random bits
      wr(8'h17, k == 3 ? 8'h09 : 8'h04);
      wr(8'h1C, k < 2 ? 8'hFF : 8'h30);
      wr(8'h1D, k < 2 ? 8'h00 : 8'h50);
      i_demod.rssi <= k == 0 ? 8'h41 : k == 1 ? 8'h40 : k == 2 ? 8'h45 : 8'h60;
      start;
      count_to(2, 300, n);
      check(n, (k == 0 || k == 3) ? 1 : 300);
    end
    i_demod.rssi <= 8'h00;
    for (int k = 0; k < 9; k++) begin
      wr(8'h25, k == 8 ? 8'h00 : {3'(k), 5'h01});
      start;
      count_to(0, 40000, n);
      check(n, k == 8 ? 32 * 4 * 64 : (4 << k) * 64);
    end
    wr(8'h17, 8'h05);
    for (int k = 3; k < 7; k += 3) begin
      wr(8'h1D, 8'(k));
      i_demod.t16_tick <= 1;
      i_demod.sig_rec <= 1;
      start;
      count_to(2, 20, n);
      check(n, k);
    end
    i_demod <= '0;
    $display("level criteria done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h27, k == 2 ? 8'h00 : 8'(k + 1));
      start;
      count_to(1, 600, n);
      check(n, k == 2 ? 600 : (k + 1) * 8);
    end
    wr(8'h27, 8'h03);
    start;
    repeat (10) @(posedge i_clk);
    start;
    count_to(1, 600, n);
    check(n, 24);
    start;
    i_demod.sym_sync <= 1;
    count_to(1, 600, n);
    check(n, 600);
    $display("sync timeout done");
    close_out();
  end
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
endmodule // tb_rwt_core
